/* rtl/adc_sample_packetiser_control.sv */
// Converter control: input sequencing, sample formatting and packetising
// How it works
// - Dropped flag sets on loss, clears on read
// - Width code 0 sends top eight bits
// - Width code 1 sends 16 bits, MSB first
// - Width code 3 sends 32 bits, MSB first
// - Close packet after programmed sample count
// - Count zero: close on register access
// - Calibration bit selects internal reference
// - Enable converts; per-input registers then read-only
// - Six warm-up pulses produce no packets
// - Seventh pulse onward delivers samples
// - Warm-up restarts on every enable rise
// - Each trigger rise converts next input
// - Only enabled inputs join the sequence
// - Samples go to input's destination
// - Results are twelve bits before formatting
`default_nettype none
module adc_sample_packetiser_control (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  // Register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // Converter front end
  input  wire logic        i_trigger,
  input  wire logic [11:0] i_conv_data,
  output logic [1:0]       o_conv_sel,
  output logic             o_cal_select,
  // Outgoing link toward the channel-end
  output logic             o_link_valid,
  output logic [7:0]       o_link_byte,
  output logic             o_link_end,
  output logic [23:0]      o_link_dest,
  input  wire logic        i_link_ready
);
  localparam int NI = conv_pkg::NUM_INPUTS;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [2:0]  trig_sync_q;
  logic [11:0] data_s1_q;
  logic [11:0] data_s2_q;
  logic        trig_rise;

  logic [NI-1:0] in_en_q;
  logic [23:0]   in_dest_q [NI];
  logic          en_q;
  logic          cal_q;
  logic [7:0]    spp_q;
  logic [1:0]    wid_q;
  logic          drop_q;

  logic          in_sel;
  logic          wr_in;
  logic          wr_gen;
  logic          rd_gen;
  logic          en_rise;
  logic [2:0]    warm_q;
  logic [1:0]    last_q;
  logic          take;
  logic          fifo_wr_ready;
  logic          fifo_rd_valid;
  logic          fifo_pop;
  logic [conv_pkg::ENTRY_W-1:0] fifo_wdata;
  logic [conv_pkg::ENTRY_W-1:0] fifo_rdata;

  conv_pkg::link_state_type state_q;
  logic [31:0] shift_q;
  logic [1:0]  bytes_left_q;
  logic [7:0]  pkt_cnt_q;
  logic        pkt_open_q;
  logic        close_req_q;
  logic [23:0] head_dest;

  function automatic logic [1:0] next_input(input logic [1:0] cur,
                                            input logic [NI-1:0] en);
    logic [1:0] r;
    r = cur;
    for (int k = NI - 1; k >= 1; k--) begin
      if (en[2'(cur + 2'(k))]) begin
        r = 2'(cur + 2'(k));
      end
    end
    return r;
  endfunction : next_input

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pin inputs synchronised; edge detect uses only the second stage onward
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_sync_q <= 3'h0;
      data_s1_q   <= 12'h000;
      data_s2_q   <= 12'h000;
    end else if (i_ce) begin
      trig_sync_q <= {trig_sync_q[1:0], i_trigger};
      data_s1_q   <= i_conv_data;
      data_s2_q   <= data_s1_q;
    end
  end
  assign trig_rise = trig_sync_q[1] && !trig_sync_q[2];

  // Per-input words sit at 0x00 to 0x0C; bits 3:2 pick the input
  assign in_sel = (i_reg_addr[7:4] == conv_pkg::OFS_INPUT_BASE[7:4])
                  && (i_reg_addr[1:0] == 2'h0);
  assign wr_in  = i_reg_wr && in_sel;
  assign wr_gen = i_reg_wr && (i_reg_addr == conv_pkg::OFS_GENERAL);
  assign rd_gen = i_reg_rd && (i_reg_addr == conv_pkg::OFS_GENERAL);
  assign en_rise = wr_gen && !en_q && i_reg_wdata[conv_pkg::GEN_EN_BIT];

  // Per-input control, write-locked while enabled
  for (genvar g = 0; g < NI; g++) begin : g_input
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        in_en_q[g]   <= 1'b0;
        in_dest_q[g] <= 24'h000000;
      end else if (i_ce && wr_in && !en_q
                   && i_reg_addr[3:2] == 2'(g)) begin
        in_en_q[g]   <= i_reg_wdata[conv_pkg::IN_EN_BIT];
        in_dest_q[g] <= i_reg_wdata[conv_pkg::IN_DEST_MSB:
                                    conv_pkg::IN_DEST_LSB];
      end
    end
  end

  // General control
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q  <= conv_pkg::RST_EN;
      cal_q <= conv_pkg::RST_CAL;
      spp_q <= conv_pkg::RST_SPP;
      wid_q <= conv_pkg::RST_WIDTH;
    end else if (i_ce && wr_gen) begin
      en_q  <= i_reg_wdata[conv_pkg::GEN_EN_BIT];
      cal_q <= i_reg_wdata[conv_pkg::GEN_CAL_BIT];
      spp_q <= i_reg_wdata[conv_pkg::GEN_SPP_MSB:conv_pkg::GEN_SPP_LSB];
      wid_q <= i_reg_wdata[conv_pkg::GEN_WID_MSB:conv_pkg::GEN_WID_LSB];
    end
  end

  // Dropped flag: a loss in the read cycle survives the clear
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      drop_q <= conv_pkg::RST_DROP;
    end else if (i_ce) begin
      if (take && !fifo_wr_ready) begin
        drop_q <= 1'b1;
      end else if (rd_gen) begin
        drop_q <= 1'b0;
      end
    end
  end

  // Register read data
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata  <= 32'h00000000;
      o_reg_rvalid <= 1'b0;
    end else if (i_ce) begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata  <= 32'h00000000;
      if (rd_gen) begin
        o_reg_rdata <= {7'h00, drop_q, 6'h00, wid_q, spp_q, 6'h00,
                        cal_q, en_q};
      end else if (i_reg_rd && in_sel) begin
        o_reg_rdata <= {in_dest_q[i_reg_addr[3:2]], 7'h00,
                        in_en_q[i_reg_addr[3:2]]};
      end
    end
  end

  // Warm-up count restarts on each enable rise
  assign take = en_q && trig_rise && (warm_q == conv_pkg::WARMUP_PULSES)
                && (in_en_q != '0);
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 3'h0;
    end else if (i_ce) begin
      if (en_rise) begin
        warm_q <= 3'h0;
      end else if (en_q && trig_rise
                   && warm_q != conv_pkg::WARMUP_PULSES) begin
        warm_q <= warm_q + 3'h1;
      end
    end
  end

  // Input sequencing: the mux always points at the next enabled input
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_q       <= 2'h3;
      o_conv_sel   <= 2'h0;
      o_cal_select <= 1'b0;
    end else if (i_ce) begin
      o_cal_select <= cal_q;
      if (en_q && trig_rise) begin
        last_q <= o_conv_sel;
      end
      o_conv_sel <= next_input(last_q, in_en_q);
    end
  end

  // Queue entry: destination, raw 12-bit result, byte count less one
  assign fifo_wdata = {in_dest_q[o_conv_sel], data_s2_q,
                       (wid_q == conv_pkg::WID_8)  ? 2'h0 :
                       (wid_q == conv_pkg::WID_32) ? 2'h3 :
                                                     2'h1};

  sample_fifo #(
    .WIDTH (conv_pkg::ENTRY_W),
    .DEPTH (conv_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk      (i_clk),
    .i_rst_n    (rst_n),
    .i_ce       (i_ce),
    .i_wr_valid (take),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (fifo_wdata),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_pop),
    .o_rd_data  (fifo_rdata)
  );

  assign head_dest = fifo_rdata[conv_pkg::ENTRY_W-1 -: 24];
  assign fifo_pop  = (state_q == conv_pkg::ST_IDLE) && fifo_rd_valid
                     && !(pkt_open_q && (close_req_q
                          || head_dest != o_link_dest));

  // Close request on any register access while the count is zero
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      close_req_q <= 1'b0;
    end else if (i_ce) begin
      if ((i_reg_wr || i_reg_rd) && spp_q == 8'h00) begin
        close_req_q <= 1'b1;
      end else if (!pkt_open_q
                   || (state_q == conv_pkg::ST_END && i_link_ready)) begin
        close_req_q <= 1'b0;
      end
    end
  end

  // Link serialiser, most significant byte first
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= conv_pkg::ST_IDLE;
      shift_q      <= 32'h00000000;
      bytes_left_q <= 2'h0;
      pkt_cnt_q    <= 8'h00;
      pkt_open_q   <= 1'b0;
      o_link_valid <= 1'b0;
      o_link_byte  <= 8'h00;
      o_link_end   <= 1'b0;
      o_link_dest  <= 24'h000000;
    end else if (i_ce) begin
      unique case (state_q)
        conv_pkg::ST_IDLE: begin
          if (pkt_open_q && (close_req_q || (fifo_rd_valid
              && head_dest != o_link_dest))) begin
            state_q      <= conv_pkg::ST_END;
            o_link_valid <= 1'b1;
            o_link_end   <= 1'b1;
          end else if (fifo_pop) begin
            // Left aligned: padding zeros fall below the result
            shift_q      <= {fifo_rdata[5:2], 28'h0000000};
            o_link_byte  <= fifo_rdata[13:6];
            bytes_left_q <= fifo_rdata[1:0];
            o_link_dest  <= head_dest;
            o_link_valid <= 1'b1;
            o_link_end   <= 1'b0;
            pkt_open_q   <= 1'b1;
            state_q      <= conv_pkg::ST_SEND;
          end
        end
        conv_pkg::ST_SEND: begin
          if (i_link_ready) begin
            if (bytes_left_q != 2'h0) begin
              o_link_byte  <= shift_q[31:24];
              shift_q      <= {shift_q[23:0], 8'h00};
              bytes_left_q <= bytes_left_q - 2'h1;
            end else if (spp_q != 8'h00
                         && pkt_cnt_q + 8'h01 == spp_q) begin
              pkt_cnt_q  <= 8'h00;
              o_link_end <= 1'b1;
              state_q    <= conv_pkg::ST_END;
            end else begin
              pkt_cnt_q    <= pkt_cnt_q + 8'h01;
              o_link_valid <= 1'b0;
              state_q      <= conv_pkg::ST_IDLE;
            end
          end
        end
        conv_pkg::ST_END: begin
          if (i_link_ready) begin
            o_link_valid <= 1'b0;
            o_link_end   <= 1'b0;
            pkt_open_q   <= 1'b0;
            pkt_cnt_q    <= 8'h00;
            state_q      <= conv_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : adc_sample_packetiser_control
`default_nettype wire

/* rtl/conv_pkg.sv */
// Shared constants for the converter sample packetiser
`default_nettype none
package conv_pkg;
  localparam int          NUM_INPUTS     = 4;
  localparam int          RESULT_W       = 12;
  localparam int          DEST_W         = 24;
  localparam int          ADDR_W         = 8;
  // Register byte offsets
  localparam logic [7:0]  OFS_INPUT_BASE = 8'h00;
  localparam logic [7:0]  OFS_GENERAL    = 8'h20;
  // Per-input control fields
  localparam int          IN_EN_BIT      = 0;
  localparam int          IN_DEST_LSB    = 8;
  localparam int          IN_DEST_MSB    = 31;
  // General control fields
  localparam int          GEN_EN_BIT     = 0;
  localparam int          GEN_CAL_BIT    = 1;
  localparam int          GEN_SPP_LSB    = 8;
  localparam int          GEN_SPP_MSB    = 15;
  localparam int          GEN_WID_LSB    = 16;
  localparam int          GEN_WID_MSB    = 17;
  localparam int          GEN_DROP_BIT   = 24;
  // Reset values of general control fields
  localparam logic        RST_DROP       = 1'b1;
  localparam logic [1:0]  RST_WIDTH      = 2'h1;
  localparam logic [7:0]  RST_SPP        = 8'h01;
  localparam logic        RST_CAL        = 1'b0;
  localparam logic        RST_EN         = 1'b0;
  // Sample width codes
  localparam logic [1:0]  WID_8          = 2'h0;
  localparam logic [1:0]  WID_16         = 2'h1;
  localparam logic [1:0]  WID_32         = 2'h3;
  // Trigger pulses swallowed after each enable
  localparam logic [2:0]  WARMUP_PULSES  = 3'h6;
  // Sample queue
  localparam int          FIFO_DEPTH     = 4;
  localparam int          ENTRY_W        = DEST_W + RESULT_W + 2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_END  = 3'b100
  } link_state_type;
endpackage : conv_pkg
`default_nettype wire

/* rtl/sample_fifo.sv */
// Small synchronous FIFO holding samples waiting for the link
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  assign push       = i_wr_valid && o_wr_ready;
  assign pop        = o_rd_valid && i_rd_ready;
  assign o_wr_ready = (count_q != (PW+1)'(DEPTH));
  assign o_rd_valid = (count_q != '0);
  assign o_rd_data  = mem_q[rd_ptr_q];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem_q[wr_ptr_q] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : sample_fifo
`default_nettype wire

/* sim/link_sink.sv */
// Channel-end receiver model: accepts beats, may pace slowly or stall
`default_nettype none
module link_sink (
  input  wire logic i_clk,
  input  wire logic i_stall,
  input  wire logic i_slow,
  output logic      o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic toggle_q = 1'b0;
  initial o_ready = 1'b0;
  // Registered so ready only ever moves just after a rising edge
  always @(posedge i_clk) begin
    toggle_q <= ~toggle_q;
    o_ready  <= !i_stall && (!i_slow || toggle_q);
  end
endmodule : link_sink
`default_nettype wire

/* sim/adc_sample_packetiser_control_properties.sv */
// Checker for the register port and the outgoing link
`default_nettype none
module adc_pkt_properties (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        o_reg_rvalid,
  input wire logic        o_cal_select,
  input wire logic        o_link_valid,
  input wire logic [7:0]  o_link_byte,
  input wire logic        o_link_end,
  input wire logic [23:0] o_link_dest,
  input wire logic        i_link_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wid_q;
  logic [7:0] spp_q;
  logic       cal_q;
  logic [7:0] rd_addr_q;
  logic [9:0] idx_q;
  logic [2:0] nb;
  wire        gen_wr = i_ce && i_reg_wr && i_reg_addr == 8'h20;
  wire        data_beat = o_link_valid && !o_link_end;
  // Mirrors general fields so beat checks know the active format
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wid_q <= 2'h1;
      spp_q <= 8'h01;
      cal_q <= 1'b0;
    end else if (gen_wr) begin
      wid_q <= i_reg_wdata[17:16];
      spp_q <= i_reg_wdata[15:8];
      cal_q <= i_reg_wdata[1];
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_addr_q <= 8'h00;
    end else if (i_ce && i_reg_rd) begin
      rd_addr_q <= i_reg_addr;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_q <= 10'h000;
    end else if (i_ce && o_link_valid && i_link_ready) begin
      idx_q <= o_link_end ? 10'h000 : idx_q + 10'h001;
    end
  end
  assign nb = (wid_q == 2'h0) ? 3'h1 : (wid_q == 2'h3) ? 3'h4 : 3'h2;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_read_answer: assert property (i_ce && i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_pulse: assert property (
    !(i_ce && i_reg_rd) |=> !o_reg_rvalid)
    else $error("read valid without a read");
  a_general_resv: assert property (
    o_reg_rvalid && rd_addr_q == 8'h20 |->
    o_reg_rdata[31:25] == 7'h00 && o_reg_rdata[23:18] == 6'h00 &&
    o_reg_rdata[7:2] == 6'h00)
    else $error("reserved general bits not zero");
  a_cal_follows: assert property (
    gen_wr |=> ##[0:1] o_cal_select == cal_q)
    else $error("reference select does not follow register");
  a_beat_stable: assert property (
    o_link_valid && !i_link_ready |=>
    $stable({o_link_byte, o_link_end, o_link_dest}))
    else $error("beat changed while stalled");
  a_valid_hold: assert property (
    o_link_valid && !i_link_ready |=> o_link_valid)
    else $error("beat withdrawn before acceptance");
  a_wid16_pad: assert property (
    data_beat && wid_q == 2'h1 && idx_q[0] |-> o_link_byte[3:0] == 4'h0)
    else $error("16-bit sample padding wrong");
  a_wid32_pad: assert property (
    data_beat && wid_q == 2'h3 && idx_q[1:0] != 2'h0 |->
    (idx_q[1:0] == 2'h1) ? o_link_byte[3:0] == 4'h0 : o_link_byte == 8'h00)
    else $error("32-bit sample padding wrong");
  a_pkt_length: assert property (
    data_beat && spp_q != 8'h00 |-> idx_q < 10'(spp_q) * 10'(nb))
    else $error("packet longer than programmed");
  c_read: cover property (o_reg_rvalid && rd_addr_q == 8'h20);
  c_drop: cover property (o_reg_rvalid && rd_addr_q == 8'h20
    && o_reg_rdata[24]);
  c_end: cover property (o_link_valid && o_link_end && i_link_ready);
  c_stall: cover property (o_link_valid && !i_link_ready);
endmodule : adc_pkt_properties
bind adc_sample_packetiser_control adc_pkt_properties chk (.i_clk, .i_rstn,
  .i_ce, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .o_cal_select, .o_link_valid, .o_link_byte, .o_link_end,
  .o_link_dest, .i_link_ready);
`default_nettype wire

/* sim/adc_sample_packetiser_control_test.sv */
// Self-checking bench for the converter sample packetiser
`default_nettype none
module adc_sample_packetiser_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_trigger = 1'b0;
  logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [7:0]  i_reg_addr = 8'h00, o_link_byte;
  logic [31:0] i_reg_wdata = 32'h0, o_reg_rdata, rv;
  logic [11:0] i_conv_data = 12'h000;
  logic [1:0]  o_conv_sel;
  logic        o_reg_rvalid, o_cal_select, o_link_valid, o_link_end;
  logic        i_link_ready;
  logic [23:0] o_link_dest;
  logic [32:0] beats[$];
  int          n_mismatch = 0, cmp_count = 0, cycles = 0;
  always #4 i_clk = ~i_clk;
  adc_sample_packetiser_control DUT (.i_clk, .i_rstn, .i_ce, .i_reg_wr,
    .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
    .i_trigger, .i_conv_data, .o_conv_sel, .o_cal_select, .o_link_valid,
    .o_link_byte, .o_link_end, .o_link_dest, .i_link_ready);
  link_sink partner (.i_clk(i_clk), .i_stall(stall), .i_slow(slow),
    .o_ready(i_link_ready));
  task automatic give_verdict();
    $display("Mismatches %0d in %0d checks", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  always @(posedge i_clk) begin
    if (o_link_valid && i_link_ready) beats.push_back({o_link_end,
      o_link_dest, o_link_byte});
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clk);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    check({31'h0, o_reg_rvalid}, 32'h1);
    d = o_reg_rdata;
  endtask : reg_rd
  // Pulses spaced well beyond the synchroniser and edge detect delay
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge i_clk);
      i_trigger = 1'b1;
      repeat (2) @(negedge i_clk);
      i_trigger = 1'b0;
      repeat (6) @(negedge i_clk);
    end
  endtask : pulse
  task automatic expect_pkt(input logic [23:0] d, input int n,
                            input logic [31:0] b, input logic closed);
    logic [32:0] bt;
    for (int i = 0; i < n + closed; i++) begin
      repeat (200) if (beats.size() == 0) @(negedge i_clk);
      bt = (beats.size() > 0) ? beats.pop_front() : 33'h0;
      // Byte of an end token carries nothing and is not compared
      check(bt[31:0], {d, (i == n) ? bt[7:0] : b[31-8*i -: 8]});
      check({31'h0, bt[32]}, {31'h0, i == n});
    end
  endtask : expect_pkt
  task automatic quiet();
    repeat (30) @(negedge i_clk);
    check(32'(beats.size()), 32'h0);
  endtask : quiet
  initial begin
    repeat (10) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    reg_rd(8'h20, rv);
    check(rv, 32'h0101_0100);
    reg_rd(8'h20, rv);
    check(rv, 32'h0001_0100);
    reg_rd(8'h40, rv);
    check(rv, 32'h0000_0000);
    reg_wr(8'h00, 32'hA1B2_C301);
    reg_wr(8'h08, 32'h4455_6601);
    reg_wr(8'h20, 32'h0001_0101);
    reg_wr(8'h00, 32'h0000_0000);
    reg_rd(8'h00, rv);
    check(rv, 32'hA1B2_C301);
    i_conv_data = 12'hABC;
    slow = 1'b1;
    pulse(6);
    quiet();
    pulse(1);
    expect_pkt(24'hA1B2C3, 2, 32'hABC0_0000, 1);
    // Inputs 0 and 2 enabled: after converting 0 the mux points at 2
    check(32'(o_conv_sel), 32'h2);
    i_conv_data = 12'h5A5;
    pulse(1);
    expect_pkt(24'h445566, 2, 32'h5A50_0000, 1);
    slow = 1'b0;
    reg_wr(8'h20, 32'h0000_0000);
    reg_wr(8'h08, 32'h4455_6600);
    reg_wr(8'h20, 32'h0000_0201);
    i_conv_data = 12'hFFF;
    pulse(6);
    i_conv_data = 12'h123;
    pulse(1);
    i_conv_data = 12'h456;
    pulse(1);
    expect_pkt(24'hA1B2C3, 2, 32'h1245_0000, 1);
    reg_wr(8'h20, 32'h0000_0000);
    reg_wr(8'h20, 32'h0003_0101);
    pulse(6);
    i_conv_data = 12'h789;
    pulse(1);
    expect_pkt(24'hA1B2C3, 4, 32'h7890_0000, 1);
    reg_wr(8'h20, 32'h0000_0000);
    reg_wr(8'h20, 32'h0001_0003);
    @(negedge i_clk);
    check({31'h0, o_cal_select}, 32'h1);
    // First samples after the reference change fall in warm-up
    pulse(6);
    i_conv_data = 12'hABC;
    pulse(1);
    i_conv_data = 12'hDEF;
    pulse(1);
    expect_pkt(24'hA1B2C3, 4, 32'hABC0_DEF0, 0);
    quiet();
    reg_rd(8'h20, rv);
    expect_pkt(24'hA1B2C3, 0, 32'h0, 1);
    reg_wr(8'h20, 32'h0000_0000);
    reg_wr(8'h20, 32'h0001_0101);
    pulse(6);
    stall = 1'b1;
    pulse(8);
    reg_rd(8'h20, rv);
    check({31'h0, rv[24]}, 32'h1);
    stall = 1'b0;
    repeat (200) @(negedge i_clk);
    // One sample in flight plus four queued survive; the rest are lost
    repeat (5) expect_pkt(24'hA1B2C3, 2, 32'hDEF0_0000, 1);
    // A trigger edge while the clock enable is low must not be seen
    i_ce = 1'b0;
    pulse(1);
    i_ce = 1'b1;
    quiet();
    reg_rd(8'h20, rv);
    check(rv, 32'h0001_0101);
    give_verdict();
  end
endmodule : adc_sample_packetiser_control_test
`default_nettype wire
